// >>> logic/diag_reporter.sv
/*
 * Builds the group diagnostic flag and the acyclic diagnostic request.
 * Assumes the status flags and enables are registers of the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module diag_reporter #(
    parameter int NUM_FLAGS = 4
) (
    input  wire logic                 clock_in,
    input  wire logic                 rst_n_in,
    input  wire logic [NUM_FLAGS-1:0] frame_status_flag_in,
    input  wire logic [NUM_FLAGS-1:0] group_diag_contrib_enable_in,
    input  wire logic [NUM_FLAGS-1:0] status_eval_enable_in,
    output logic                      group_diag_flag_out,
    output logic                      diag_msg_req_out
);

    logic armed;
    logic next_group_diag_flag;
    logic next_diag_msg_req;
    logic next_armed;
    logic reportable;

    always_comb begin
        next_group_diag_flag = |(frame_status_flag_in & group_diag_contrib_enable_in);
        // Only flags with evaluation enabled raise a message
        reportable        = |(frame_status_flag_in & group_diag_contrib_enable_in
                              & status_eval_enable_in);
        next_diag_msg_req = reportable && !armed;
        next_armed        = reportable;
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            group_diag_flag_out <= 1'b0;
            diag_msg_req_out    <= 1'b0;
            armed               <= 1'b0;
        end else begin
            group_diag_flag_out <= next_group_diag_flag;
            diag_msg_req_out    <= next_diag_msg_req;
            armed               <= next_armed;
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    chk_group_diag_or: assert property (
        ##1 group_diag_flag_out == $past(|(frame_status_flag_in & group_diag_contrib_enable_in))
    ) else $error("group diagnostic flag does not match enabled flags");

    chk_group_diag_zero: assert property (
        ((frame_status_flag_in & group_diag_contrib_enable_in) == '0) |=> !group_diag_flag_out
    ) else $error("group diagnostic flag set with no enabled flag active");

    chk_msg_single_pulse: assert property (
        diag_msg_req_out |=> !diag_msg_req_out
    ) else $error("diagnostic request held longer than one cycle");

endmodule

`default_nettype wire

// >>> logic/encoder_status_bit_mapper.sv
/*
 * Status extraction for an absolute encoder interface: object access to
 * the optional status byte, the encoder control byte and the status bit
 * selection register, plus the per-frame copy of selected bits into four
 * status flags and the group diagnostic.
 * Assumes object requests and frames are synchronous to clock_in; frames
 * that the reader delivers while encoder_run_out is low are dropped.
 */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Status object returns process input byte 2 as unsigned byte, read only.
// - Bits 6 and 7 of the status object always read back as zero.
// - Control object is read/write, maps to control byte 0, acts at runtime.
// - Only control bit 7, the halt command, has any effect.
// - Mapping object reads and writes internal register 51, the 32-bit selection.
// - Four selected bits of each frame are copied to flags 0..3; byte n sets flag n.
// - Selection bits 4..0 give frame bit position 0..31; default 0.
// - Selection bit 7 enables diagnostic evaluation of that flag; default off.
// - Diagnostic bit 0 and group flag are OR of flag n AND its bit 6.
// - An enabled status condition can raise an acyclic diagnostic message.
// - Encoder reading stops while halt or bad parameter error is set.
// - Group flag is 1 when any enabled flag is active, else 0.
module encoder_status_bit_mapper
    import status_map_pkg::*;
#(
    parameter int NUM_FLAGS_P = status_map_pkg::NUM_FLAGS,
    parameter int FRAME_W_P   = status_map_pkg::FRAME_W
) (
    input  wire logic                         clock_in,
    input  wire logic                         rst_n_in,
    input  wire status_map_pkg::obj_req_s     obj_req_in,
    output status_map_pkg::obj_rsp_s          obj_rsp_out,
    input  wire logic                         frame_valid_in,
    input  wire logic [FRAME_W_P-1:0]         frame_data_in,
    input  wire logic                         bad_parameter_error_in,
    output logic                              encoder_run_out,
    output logic [7:0]                        status_byte_out,
    output logic                              group_diag_flag_out,
    output logic                              diag_bit0_out,
    output logic                              diag_msg_req_out
);
    import status_map_pkg::*;

    logic [7:0]             control;
    logic [31:0]            selection;
    logic [NUM_FLAGS_P-1:0] frame_status_flag;
    obj_rsp_s               rsp;
    logic                   run;

    logic [7:0]             next_control;
    logic [31:0]            next_selection;
    logic [NUM_FLAGS_P-1:0] next_frame_status_flag;
    obj_rsp_s               next_rsp;
    logic                   next_run;

    logic [NUM_FLAGS_P-1:0] picked;
    logic [NUM_FLAGS_P-1:0] group_diag_contrib_enable;
    logic [NUM_FLAGS_P-1:0] status_eval_enable;
    logic [7:0]             status_read_value;
    logic                   frame_take;

    // Per-flag bit selection
    genvar n;
    generate
        for (n = 0; n < NUM_FLAGS_P; n++) begin : g_flag
            frame_bit_picker #(
                .FRAME_W (FRAME_W_P),
                .POS_W   (SEL_POS_W)
            ) u_pick (
                .frame_in           (frame_data_in),
                .frame_bit_index_in (selection[n*SEL_BYTE_W+SEL_POS_LSB +: SEL_POS_W]),
                .picked_bit_out     (picked[n])
            );
            assign group_diag_contrib_enable[n] = selection[n*SEL_BYTE_W+SEL_CONTRIB_BIT];
            assign status_eval_enable[n]        = selection[n*SEL_BYTE_W+SEL_EVAL_BIT];
        end
    endgenerate

    // Frames arriving while stopped are stale and dropped
    assign frame_take = frame_valid_in && run;

    always_comb begin
        next_frame_status_flag = frame_status_flag;
        if (frame_take) begin
            next_frame_status_flag = picked;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            frame_status_flag <= FLAGS_RESET;
        end else begin
            frame_status_flag <= next_frame_status_flag;
        end
    end

    // Control and selection registers written through the object port
    always_comb begin
        next_control   = control;
        next_selection = selection;
        if (obj_req_in.valid && obj_req_in.write) begin
            if (obj_req_in.index == IDX_ENC_CONTROL) begin
                next_control = obj_req_in.wdata[7:0];
            end else if (obj_req_in.index == IDX_BIT_SELECTION) begin
                next_selection = obj_req_in.wdata & SEL_WRITE_MASK;
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            control   <= CONTROL_RESET;
            selection <= SELECTION_RESET;
        end else begin
            control   <= next_control;
            selection <= next_selection;
        end
    end

    // Halt and parameter error both stop the reader; other control bits do nothing
    always_comb begin
        next_run = !(control[HALT_BIT] || bad_parameter_error_in);
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            run <= 1'b0;
        end else begin
            run <= next_run;
        end
    end

    // Object answers, one cycle after the request
    always_comb begin
        status_read_value = {{(8-NUM_FLAGS_P){1'b0}}, frame_status_flag} & STATUS_READ_MASK;
        next_rsp          = '0;
        if (obj_req_in.valid) begin
            next_rsp.valid = 1'b1;
            if (obj_req_in.index == IDX_OPT_STATUS) begin
                // Read only: a write is answered with an error
                next_rsp.error = obj_req_in.write;
                next_rsp.rdata = obj_req_in.write ? 32'h00000000
                                                  : {24'h000000, status_read_value};
            end else if (obj_req_in.index == IDX_ENC_CONTROL) begin
                next_rsp.rdata = obj_req_in.write ? 32'h00000000 : {24'h000000, control};
            end else if (obj_req_in.index == IDX_BIT_SELECTION) begin
                next_rsp.rdata = obj_req_in.write ? 32'h00000000 : selection;
            end else begin
                next_rsp.error = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rsp <= '0;
        end else begin
            rsp <= next_rsp;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_byte_out <= 8'h00;
        end else begin
            status_byte_out <= {{(8-NUM_FLAGS_P){1'b0}}, next_frame_status_flag};
        end
    end

    diag_reporter #(
        .NUM_FLAGS (NUM_FLAGS_P)
    ) u_diag (
        .clock_in                     (clock_in),
        .rst_n_in                     (rst_n_in),
        .frame_status_flag_in         (frame_status_flag),
        .group_diag_contrib_enable_in (group_diag_contrib_enable),
        .status_eval_enable_in        (status_eval_enable),
        .group_diag_flag_out          (group_diag_flag_out),
        .diag_msg_req_out             (diag_msg_req_out)
    );

    // Diagnostic bit 0 carries the same value as the group flag
    assign diag_bit0_out   = group_diag_flag_out;
    assign encoder_run_out = run;
    assign obj_rsp_out     = rsp;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    sequence seq_read_status;
        obj_req_in.valid && !obj_req_in.write && obj_req_in.index == IDX_OPT_STATUS;
    endsequence

    sequence seq_write_control;
        obj_req_in.valid && obj_req_in.write && obj_req_in.index == IDX_ENC_CONTROL;
    endsequence

    sequence seq_stop_cause;
        control[HALT_BIT] || bad_parameter_error_in;
    endsequence

    sequence seq_write_status;
        obj_req_in.valid && obj_req_in.write && obj_req_in.index == IDX_OPT_STATUS;
    endsequence

    sequence seq_read_control;
        obj_req_in.valid && !obj_req_in.write && obj_req_in.index == IDX_ENC_CONTROL;
    endsequence

    sequence seq_read_selection;
        obj_req_in.valid && !obj_req_in.write && obj_req_in.index == IDX_BIT_SELECTION;
    endsequence

    sequence seq_write_selection;
        obj_req_in.valid && obj_req_in.write && obj_req_in.index == IDX_BIT_SELECTION;
    endsequence

    sequence seq_unknown_index;
        obj_req_in.valid && obj_req_in.index != IDX_OPT_STATUS
            && obj_req_in.index != IDX_ENC_CONTROL && obj_req_in.index != IDX_BIT_SELECTION;
    endsequence

    // Control write, then the run flop sees it one edge later
    sequence seq_halt_write;
        seq_write_control ##0 obj_req_in.wdata[HALT_BIT];
    endsequence

    sequence seq_release_write;
        seq_write_control ##0 !obj_req_in.wdata[HALT_BIT] ##1 !bad_parameter_error_in;
    endsequence

    chk_answer_latency: assert property (
        obj_req_in.valid |=> obj_rsp_out.valid
    ) else $error("object request not answered in one cycle");

    chk_status_read_value: assert property (
        seq_read_status |=> !obj_rsp_out.error
            && obj_rsp_out.rdata == {24'h000000, 4'h0, $past(frame_status_flag)}
    ) else $error("status object read value wrong");

    chk_status_top_bits: assert property (
        seq_read_status |=> obj_rsp_out.rdata[7:6] == 2'b00
    ) else $error("status object bits 7 and 6 not zero");

    chk_control_write: assert property (
        seq_write_control |=> control == $past(obj_req_in.wdata[7:0])
    ) else $error("control byte write not stored");

    chk_halt_stops: assert property (
        seq_stop_cause |=> !encoder_run_out
    ) else $error("encoder still running while halted or in error");

    chk_run_resumes: assert property (
        (!control[HALT_BIT] && !bad_parameter_error_in) |=> encoder_run_out
    ) else $error("non-halt control bits stopped the encoder");

    chk_selection_bit5: assert property (
        (selection & ~SEL_WRITE_MASK) == 32'h00000000
    ) else $error("selection bit 5 retained");

    chk_flag0_copy: assert property (
        frame_take |=> frame_status_flag[0] == $past(frame_data_in[selection[SEL_POS_W-1:0]])
    ) else $error("flag 0 not copied from selected frame bit");

    chk_flags_hold: assert property (
        !frame_take |=> $stable(frame_status_flag)
    ) else $error("status flags changed without a taken frame");

    // Idle answers are all zero so a host may treat the word as a plain bus
    chk_rsp_idle_zero: assert property (
        !obj_req_in.valid |=> obj_rsp_out == '0
    ) else $error("object answer not zero without a request");

    chk_status_write_refused: assert property (
        seq_write_status |=> obj_rsp_out.error && obj_rsp_out.rdata == 32'h00000000
    ) else $error("write to status object not refused");

    chk_status_write_kept: assert property (
        seq_write_status |=> $stable(control) && $stable(selection)
    ) else $error("write to status object changed a register");

    chk_control_readback: assert property (
        seq_read_control |=> obj_rsp_out.rdata == {24'h000000, $past(control)}
    ) else $error("control byte read value wrong");

    chk_control_write_ok: assert property (
        seq_write_control |=> obj_rsp_out.valid && !obj_rsp_out.error
    ) else $error("control byte write answered with error");

    chk_selection_readback: assert property (
        seq_read_selection |=> obj_rsp_out.rdata == $past(selection)
    ) else $error("selection register read value wrong");

    chk_selection_write_mask: assert property (
        seq_write_selection |=> selection == ($past(obj_req_in.wdata) & SEL_WRITE_MASK)
    ) else $error("selection register write not stored");

    chk_unknown_index: assert property (
        seq_unknown_index |=> obj_rsp_out.error && obj_rsp_out.rdata == 32'h00000000
    ) else $error("unknown object index not refused");

    chk_low_bits_run: assert property (
        seq_release_write |=> encoder_run_out
    ) else $error("control write without halt bit stopped the encoder");

    chk_halt_write_stops: assert property (
        seq_halt_write |=> ##1 !encoder_run_out
    ) else $error("halt command write did not stop the encoder");

    chk_status_byte_image: assert property (
        status_byte_out == {{(8-NUM_FLAGS_P){1'b0}}, frame_status_flag}
    ) else $error("status byte differs from status flags");

    chk_dropped_frame: assert property (
        frame_valid_in && !encoder_run_out |=> $stable(frame_status_flag)
    ) else $error("frame taken while encoder stopped");

    for (genvar k = 0; k < NUM_FLAGS_P; k++) begin : g_copy_chk
        chk_flag_copy: assert property (
            frame_take |=> frame_status_flag[k]
                == $past(frame_data_in[selection[k*SEL_BYTE_W+SEL_POS_LSB +: SEL_POS_W]])
        ) else $error("status flag not copied from selected frame bit");
    end

endmodule

`default_nettype wire

// >>> logic/frame_bit_picker.sv
/*
 * Picks one bit of a received encoder frame by its position.
 * Assumes the position is already limited to the frame width.
 */
`timescale 1ns/1ps
`default_nettype none

module frame_bit_picker #(
    parameter int FRAME_W = 32,
    parameter int POS_W   = 5
) (
    input  wire logic [FRAME_W-1:0] frame_in,
    input  wire logic [POS_W-1:0]   frame_bit_index_in,
    output logic                    picked_bit_out
);

    always_comb begin
        picked_bit_out = frame_in[frame_bit_index_in];
    end

endmodule

`default_nettype wire

// >>> logic/status_map_pkg.sv
/*
 * Constants and carrier types for the encoder status bit mapper.
 * Assumes a single 25 MHz clock domain shared by every user of the package.
 */
package status_map_pkg;

    localparam int          NUM_FLAGS            = 4;
    localparam int          FRAME_W              = 32;
    localparam int          SEL_POS_W            = 5;

    // Object indices and the selection register number
    localparam logic [15:0] IDX_OPT_STATUS       = 16'h5806;
    localparam logic [15:0] IDX_ENC_CONTROL      = 16'h5808;
    localparam logic [15:0] IDX_BIT_SELECTION    = 16'h5840;
    localparam logic [7:0]  SELECTION_REG_NUMBER = 8'h33;

    // Field layout of one selection byte and the control byte
    localparam int          SEL_POS_LSB          = 0;
    localparam int          SEL_CONTRIB_BIT      = 6;
    localparam int          SEL_EVAL_BIT         = 7;
    localparam int          HALT_BIT             = 7;
    localparam int          SEL_BYTE_W           = 8;

    localparam logic [7:0]  STATUS_READ_MASK     = 8'h3f;
    localparam logic [31:0] SEL_WRITE_MASK       = 32'hdfdfdfdf;

    // Values after reset
    localparam logic [7:0]  CONTROL_RESET        = 8'h00;
    localparam logic [31:0] SELECTION_RESET      = 32'h00000000;
    localparam logic [3:0]  FLAGS_RESET          = 4'h0;

    localparam int          ANSWER_LATENCY       = 1;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] index;
        logic [31:0] wdata;
    } obj_req_s;

    typedef struct packed {
        logic        valid;
        logic        error;
        logic [31:0] rdata;
    } obj_rsp_s;

endpackage

// >>> verif/obj_master.sv
/*
 * Object access master standing in for the fieldbus host.
 * Assumes one request is answered exactly one cycle after it is taken.
 */
`timescale 1ns/1ps
`default_nettype none

module obj_master
    import status_map_pkg::*;
(
    input  wire logic                     clock_in,
    output var status_map_pkg::obj_req_s  obj_req_out,
    input  wire status_map_pkg::obj_rsp_s obj_rsp_in
);
    initial obj_req_out = '0;

    // Idle cycles before the request let a slow master be modelled
    task automatic access(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                          input int gap, output logic [31:0] rd, output logic err,
                          output logic ok);
        repeat (gap + 1) @(posedge clock_in);
        #1;
        obj_req_out = '{valid: 1'b1, write: wr, index: idx, wdata: wd};
        @(posedge clock_in);
        #1;
        obj_req_out = '0;
        ok  = obj_rsp_in.valid;
        rd  = obj_rsp_in.rdata;
        err = obj_rsp_in.error;
    endtask
endmodule

`default_nettype wire

// >>> verif/tb_top.sv
/*
 * Self-checking bench for the encoder status bit mapper.
 * Assumes the object master model and the design package are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import status_map_pkg::*;
    logic        clock_in;
    logic        rst_n_in;
    obj_req_s    req;
    obj_rsp_s    rsp;
    logic        frame_valid;
    logic [31:0] frame_data;
    logic        bad_param;
    logic        run;
    logic [7:0]  status_byte;
    logic        group_flag;
    logic        diag_bit0;
    logic        msg_req;
    int          mismatches;
    int          checks;
    logic [31:0] sel;
    logic [3:0]  flags;
    logic        rep;
    logic [31:0] frame_tab [4] = '{32'h00000008, 32'h80020000, 32'h00000001, 32'h00020009};

    always #20 clock_in = ~clock_in;

    encoder_status_bit_mapper dut_u (
        .clock_in              (clock_in),
        .rst_n_in              (rst_n_in),
        .obj_req_in            (req),
        .obj_rsp_out           (rsp),
        .frame_valid_in        (frame_valid),
        .frame_data_in         (frame_data),
        .bad_parameter_error_in(bad_param),
        .encoder_run_out       (run),
        .status_byte_out       (status_byte),
        .group_diag_flag_out   (group_flag),
        .diag_bit0_out         (diag_bit0),
        .diag_msg_req_out      (msg_req)
    );

    obj_master host_u (
        .clock_in   (clock_in),
        .obj_req_out(req),
        .obj_rsp_in (rsp)
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic obj(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                       input logic [31:0] exp_rd, input logic exp_err);
        logic [31:0] rd;
        logic        err;
        logic        ok;
        host_u.access(wr, idx, wd, 0, rd, err, ok);
        check("rsp valid", {31'h0, ok}, 32'h1);
        check("rsp error", {31'h0, err}, {31'h0, exp_err});
        check("rsp data", rd, exp_rd);
    endtask

    // Expected flags come from the selection as this bench last wrote it
    task automatic send_frame(input logic [31:0] d, input logic taken);
        logic [3:0] b6;
        logic [3:0] b7;
        logic       now_rep;
        b6 = {sel[30], sel[22], sel[14], sel[6]};
        b7 = {sel[31], sel[23], sel[15], sel[7]};
        if (taken) begin
            for (int n = 0; n < 4; n++) begin
                flags[n] = d[sel[8*n +: 5]];
            end
        end
        now_rep = |(flags & b6 & b7);
        @(posedge clock_in);
        #1;
        frame_valid = 1'b1;
        frame_data  = d;
        @(posedge clock_in);
        #1;
        frame_valid = 1'b0;
        frame_data  = ~d;
        check("status byte", {24'h0, status_byte}, {28'h0, flags});
        @(posedge clock_in);
        #1;
        check("group flag", {31'h0, group_flag}, {31'h0, |(flags & b6)});
        check("diag bit0", {31'h0, diag_bit0}, {31'h0, |(flags & b6)});
        check("diag msg", {31'h0, msg_req}, {31'h0, taken & now_rep & ~rep});
        rep = now_rep;
    endtask

    initial begin
        #(40 * 3000);
        mismatches++;
        summarize();
    end

    initial begin
        clock_in    = 1'b0;
        rst_n_in    = 1'b0;
        frame_valid = 1'b0;
        frame_data  = '0;
        bad_param   = 1'b0;
        mismatches  = 0;
        checks      = 0;
        sel         = '0;
        flags       = '0;
        rep         = 1'b0;
        repeat (4) @(posedge clock_in);
        #1;
        rst_n_in = 1'b1;
        @(posedge clock_in);
        #1;
        check("run after reset", {31'h0, run}, 32'h1);
        obj(1'b0, IDX_OPT_STATUS, '0, '0, 1'b0);
        obj(1'b0, IDX_ENC_CONTROL, '0, '0, 1'b0);
        obj(1'b0, IDX_BIT_SELECTION, '0, '0, 1'b0);
        send_frame(32'h00000001, 1'b1);
        obj(1'b0, IDX_OPT_STATUS, '0, 32'h0000000f, 1'b0);
        obj(1'b1, IDX_OPT_STATUS, 32'h000000ff, '0, 1'b1);
        obj(1'b0, 16'h1234, '0, '0, 1'b1);
        send_frame(32'h00000000, 1'b1);
        // Bit 5 of each byte set on purpose: it must not stick
        obj(1'b1, IDX_BIT_SELECTION, 32'hf1a03f63, '0, 1'b0);
        sel = 32'hd1801f43;
        obj(1'b0, IDX_BIT_SELECTION, '0, sel, 1'b0);
        foreach (frame_tab[i]) begin
            send_frame(frame_tab[i], 1'b1);
        end
        obj(1'b0, IDX_OPT_STATUS, '0, {28'h0, flags}, 1'b0);
        obj(1'b1, IDX_ENC_CONTROL, 32'h0000007f, '0, 1'b0);
        @(posedge clock_in);
        #1;
        check("run low bits", {31'h0, run}, 32'h1);
        obj(1'b0, IDX_ENC_CONTROL, '0, 32'h0000007f, 1'b0);
        obj(1'b1, IDX_ENC_CONTROL, 32'h00000080, '0, 1'b0);
        @(posedge clock_in);
        #1;
        check("run halted", {31'h0, run}, 32'h0);
        send_frame(32'hffffffff, 1'b0);
        obj(1'b1, IDX_ENC_CONTROL, '0, '0, 1'b0);
        @(posedge clock_in);
        #1;
        check("run resumed", {31'h0, run}, 32'h1);
        bad_param = 1'b1;
        repeat (2) @(posedge clock_in);
        #1;
        check("run bad param", {31'h0, run}, 32'h0);
        send_frame(32'h00000000, 1'b0);
        bad_param = 1'b0;
        repeat (2) @(posedge clock_in);
        #1;
        check("run cleared", {31'h0, run}, 32'h1);
        send_frame(32'h00000008, 1'b1);
        summarize();
    end
endmodule

`default_nettype wire
